// ---- pbc_bridge_ctrl.v ----
// Bridge control register with VGA/ISA routing, error forwarding and hot reset
`timescale 1ns/1ps
`include "pbc_consts.vh"
module pbc_bridge_ctrl (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        resetn_i,
   // Configuration access
   input  wire        cfg_wr_i,
   input  wire        cfg_rd_i,
   input  wire [7:0]  cfg_addr_i,
   input  wire [1:0]  cfg_be_i,
   input  wire [15:0] cfg_wdata_i,
   output reg  [15:0] cfg_rdata_o,
   // Window and root control settings from neighbouring registers
   input  wire [3:0]  io_window_base_i,
   input  wire [3:0]  io_window_limit_i,
   input  wire        io_space_enable_i,
   input  wire [2:0]  root_err_enable_i,
   // CPU transaction decode
   input  wire        cpu_io_valid_i,
   input  wire        cpu_mem_valid_i,
   input  wire [31:0] cpu_addr_i,
   output wire        route_graphics_o,
   output wire        route_legacy_o,
   // Master abort handling
   input  wire        master_abort_i,
   input  wire        master_abort_is_read_i,
   output wire        ma_complete_o,
   output wire [31:0] ma_read_data_o,
   // Secondary link events
   input  wire [2:0]  err_msg_rx_i,
   input  wire        poisoned_cpl_rx_i,
   input  wire        parity_flag_clear_i,
   output wire        system_error_o,
   output reg         master_data_parity_error_o,
   // Link training
   input  wire        link_active_i,
   input  wire        in_recovery_i,
   input  wire        in_hot_reset_i,
   output wire        req_recovery_o,
   output wire        req_hot_reset_o
);
   // Register layout
   localparam [15:0] WR_MASK   = `PBC_BCTRL_WMASK;
   localparam [15:0] RST_VALUE = `PBC_BCTRL_RESET;

   // Register storage and access
   wire [15:0] bctrl;
   wire        hit;
   wire        wr_hit;
   wire        rd_hit;
   wire [15:0] be_mask;

   // Named register fields
   wire        sbr_bit;
   wire        vga16_bit;
   wire        vga_en;
   wire        isa_bit;
   wire        serr_bit;
   wire        parity_error_response_enable_bit;

   // VGA decode
   wire [15:0] io_addr;
   wire        vga_decode_full;
   wire [15:0] vga_mask;
   wire [15:0] io_a;
   wire        vga_io_mono;
   wire        vga_io_color;
   wire        vga_io_hit;
   wire        vga_mem_hit;

   // I/O window and ISA alias decode
   wire [15:0] win_lo;
   wire [15:0] win_hi;
   wire [15:0] kb_offset;
   wire        in_window;
   wire        isa_alias;

   // Routing terms
   wire        io_vga_claim;
   wire        io_window_claim;
   wire        io_to_graphics;
   wire        mem_to_graphics;
   wire        any_request;

   // Error and parity terms
   wire [2:0]  class_fwd;
   wire        parity_set;
   wire        ma_read_abort;

   assign hit     = (cfg_addr_i == `PBC_BCTRL_OFFSET);
   assign wr_hit  = cfg_wr_i && hit;
   assign rd_hit  = cfg_rd_i && hit;
   assign be_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

   // One flop per writable bit; hardwired bits are tied low so no write can reach them
   genvar gb;
   generate
      for (gb = 0; gb < `PBC_BCTRL_BITS; gb = gb + 1) begin : g_bctrl_bit
         if (WR_MASK[gb]) begin : g_rw
            reg q;
            always @(posedge sys_clk_i or negedge resetn_i) begin
               if (!resetn_i) begin
                  q <= RST_VALUE[gb];
               end else if (wr_hit && be_mask[gb]) begin
                  q <= cfg_wdata_i[gb];
               end
            end
            assign bctrl[gb] = q;
         end else begin : g_ro
            assign bctrl[gb] = 1'b0;
         end
      end
   endgenerate

   // Read data stands one cycle and is zero otherwise, so several sources can be ORed
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_rdata_o <= 16'h0000;
      end else if (rd_hit) begin
         cfg_rdata_o <= bctrl & WR_MASK;
      end else begin
         cfg_rdata_o <= 16'h0000;
      end
   end

   // Field taps
   assign sbr_bit   = bctrl[`PBC_BIT_SBR];
   assign vga16_bit = bctrl[`PBC_BIT_VGA16];
   assign vga_en    = bctrl[`PBC_BIT_VGA_ROUTING_ENABLE];
   assign isa_bit   = bctrl[`PBC_BIT_ISA_ALIAS_EXCLUDE_ENABLE];
   assign serr_bit  = bctrl[`PBC_BIT_SYSTEM_ERROR_FORWARD_ENABLE];
   assign parity_error_response_enable_bit = bctrl[`PBC_BIT_PARITY_ERROR_RESPONSE_ENABLE];

   // Upper bits are ignored in 10-bit mode so the 1 KB aliases also hit
   assign io_addr         = cpu_addr_i[15:0];
   assign vga_decode_full = vga_en && vga16_bit;
   assign vga_mask        = vga_decode_full ? `PBC_VGA_MASK16 : `PBC_VGA_MASK10;
   assign io_a            = io_addr & vga_mask;
   assign vga_io_mono     = (io_a >= `PBC_VGA_IO_LO1) && (io_a <= `PBC_VGA_IO_HI1);
   assign vga_io_color    = (io_a >= `PBC_VGA_IO_LO2) && (io_a <= `PBC_VGA_IO_HI2);
   assign vga_io_hit      = vga_io_mono || vga_io_color;
   assign vga_mem_hit     = (cpu_addr_i >= `PBC_VGA_MEM_LO) &&
                            (cpu_addr_i <= `PBC_VGA_MEM_HI);

   // The window works on 4 KB granules; the low twelve address bits are implied
   assign win_lo    = {io_window_base_i, `PBC_WIN_LO_BITS};
   assign win_hi    = {io_window_limit_i, `PBC_WIN_HI_BITS};
   assign in_window = io_space_enable_i &&
                      (io_addr >= win_lo) &&
                      (io_addr <= win_hi);
   // Offsets 0x100 to 0x3ff of every KB are the ISA aliases
   assign kb_offset = io_addr & `PBC_KB_MASK;
   assign isa_alias = isa_bit && (kb_offset >= `PBC_ISA_ALIAS_LO);

   assign io_vga_claim    = vga_en && vga_io_hit;
   // The ISA exclusion is only looked at inside the window
   assign io_window_claim = in_window && !isa_alias;
   assign io_to_graphics  = cpu_io_valid_i &&
                            (io_vga_claim || io_window_claim);
   assign mem_to_graphics = cpu_mem_valid_i && vga_en &&
                            vga_mem_hit;
   assign any_request     = cpu_io_valid_i || cpu_mem_valid_i;

   assign route_graphics_o = io_to_graphics || mem_to_graphics;
   // Whatever the graphics port does not claim goes down the legacy link
   assign route_legacy_o   = any_request && !route_graphics_o;

   // Master abort is hardwired to the normal-completion mode
   // Write aborts complete with no data; the write payload is simply dropped
   assign ma_read_abort  = master_abort_i && master_abort_is_read_i;
   assign ma_complete_o  = master_abort_i;
   assign ma_read_data_o = ma_read_abort ? `PBC_MA_READ_DATA :
                                           32'h00000000;

   // One gate per error class, each also under its own root-control enable
   genvar ge;
   generate
      for (ge = 0; ge < `PBC_ERR_CLASSES; ge = ge + 1) begin : g_err_class
         assign class_fwd[ge] = serr_bit && err_msg_rx_i[ge] &&
                                root_err_enable_i[ge];
      end
   endgenerate
   assign system_error_o = |class_fwd;

   // Set wins over clear in the same cycle, so no poisoned completion is lost
   assign parity_set = poisoned_cpl_rx_i && parity_error_response_enable_bit;
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         master_data_parity_error_o <= 1'b0;
      end else if (parity_set) begin
         master_data_parity_error_o <= 1'b1;
      end else if (parity_flag_clear_i) begin
         master_data_parity_error_o <= 1'b0;
      end
   end

   // The request is held for as long as software keeps the reset bit set
   pbc_hot_reset_seq u_hot_reset (
      .sys_clk_i       (sys_clk_i),
      .resetn_i        (resetn_i),
      .reset_bit_i     (sbr_bit),
      .link_active_i   (link_active_i),
      .in_recovery_i   (in_recovery_i),
      .in_hot_reset_i  (in_hot_reset_i),
      .req_recovery_o  (req_recovery_o),
      .req_hot_reset_o (req_hot_reset_o)
   );
endmodule // pbc_bridge_ctrl

// ---- pbc_consts.vh ----
// Constants for the bridge control register block
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH
`define PBC_BCTRL_OFFSET   8'h3e
`define PBC_BCTRL_RESET    16'h0000
`define PBC_BCTRL_WMASK    16'h005f
`define PBC_BCTRL_BITS     16
`define PBC_ERR_CLASSES    3
`define PBC_BIT_SBR        6
`define PBC_BIT_VGA16      4
`define PBC_BIT_VGA_ROUTING_ENABLE      3
`define PBC_BIT_ISA_ALIAS_EXCLUDE_ENABLE      2
`define PBC_BIT_SYSTEM_ERROR_FORWARD_ENABLE     1
`define PBC_BIT_PARITY_ERROR_RESPONSE_ENABLE      0
`define PBC_VGA_MASK10     16'h03ff
`define PBC_VGA_MASK16     16'hffff
`define PBC_KB_MASK        16'h03ff
`define PBC_ISA_ALIAS_LO   16'h0100
`define PBC_MA_READ_DATA   32'hffffffff
`define PBC_WIN_LO_BITS    12'h000
`define PBC_WIN_HI_BITS    12'hfff
`define PBC_VGA_IO_LO1     16'h03b0
`define PBC_VGA_IO_HI1     16'h03bb
`define PBC_VGA_IO_LO2     16'h03c0
`define PBC_VGA_IO_HI2     16'h03df
`define PBC_VGA_MEM_LO     32'h000a0000
`define PBC_VGA_MEM_HI     32'h000bffff
`endif

// ---- pbc_hot_reset_seq.v ----
// Hot reset request sequencer toward the link training state machine
`timescale 1ns/1ps
module pbc_hot_reset_seq (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        resetn_i,
   // Control
   input  wire        reset_bit_i,
   input  wire        link_active_i,
   input  wire        in_recovery_i,
   input  wire        in_hot_reset_i,
   // Requests to link training
   output wire        req_recovery_o,
   output wire        req_hot_reset_o
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RECV = 3'b010;
   localparam [2:0] ST_HOT  = 3'b100;
   reg [2:0] state;
   reg [2:0] next_state;
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: if (reset_bit_i && link_active_i) next_state = ST_RECV;
         ST_RECV: if (!reset_bit_i) next_state = ST_IDLE;
                  else if (in_recovery_i) next_state = ST_HOT;
         ST_HOT:  if (!reset_bit_i) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   // Hot reset is held while software keeps the bit set
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) state <= ST_IDLE;
      else state <= next_state;
   end
   assign req_recovery_o  = (state == ST_RECV);
   assign req_hot_reset_o = (state == ST_HOT) && !in_hot_reset_i ? 1'b1 : (state == ST_HOT);
endmodule // pbc_hot_reset_seq

// ---- pbc_bridge_ctrl_props.sv ----
// Port checker for the bridge control register
`timescale 1ns/1ps
module pbc_bridge_ctrl_props (
   input wire logic        sys_clk_i, resetn_i, cfg_rd_i, cpu_io_valid_i, cpu_mem_valid_i,
   input wire logic        route_graphics_o, route_legacy_o, master_abort_i, ma_complete_o,
   input wire logic        master_abort_is_read_i, system_error_o, poisoned_cpl_rx_i,
   input wire logic        master_data_parity_error_o, in_recovery_i, req_recovery_o,
   input wire logic        req_hot_reset_o,
   input wire logic [7:0]  cfg_addr_i,
   input wire logic [15:0] cfg_rdata_o,
   input wire logic [31:0] ma_read_data_o,
   input wire logic [2:0]  err_msg_rx_i, root_err_enable_i
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_hw_zero; cfg_rd_i |=> (cfg_rdata_o & 16'hffa0) == 16'h0000; endproperty
   a_hw_zero: assert property (p_hw_zero) else $error("hardwired bit read as one");
   property p_rd_idle; !(cfg_rd_i && cfg_addr_i == 8'h3e) |=> cfg_rdata_o == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
   property p_hr_rec; $rose(req_hot_reset_o) |-> $past(in_recovery_i) && !req_recovery_o; endproperty
   a_hr_rec: assert property (p_hr_rec) else $error("hot reset skipped recovery");
   property p_ma_rd; master_abort_i && master_abort_is_read_i |-> ma_complete_o
      && ma_read_data_o == 32'hffffffff; endproperty
   a_ma_rd: assert property (p_ma_rd) else $error("aborted read not all ones");
   property p_ma_only; ma_complete_o |-> master_abort_i; endproperty
   a_ma_only: assert property (p_ma_only) else $error("abort completion without abort");
   property p_route_one; route_graphics_o |-> !route_legacy_o; endproperty
   a_route_one: assert property (p_route_one) else $error("routed to both sides");
   property p_route_idle; !cpu_io_valid_i && !cpu_mem_valid_i |-> !route_graphics_o
      && !route_legacy_o; endproperty
   a_route_idle: assert property (p_route_idle) else $error("route without request");
   property p_serr; system_error_o |-> (err_msg_rx_i & root_err_enable_i) != 3'h0; endproperty
   a_serr: assert property (p_serr) else $error("system error without enabled message");
   property p_par; $rose(master_data_parity_error_o) |-> $past(poisoned_cpl_rx_i); endproperty
   a_par: assert property (p_par) else $error("parity flag without poisoned data");
endmodule // pbc_bridge_ctrl_props
bind pbc_bridge_ctrl pbc_bridge_ctrl_props pbc_bridge_ctrl_props_i (.*);

// ---- pbc_ltssm_model.sv ----
// Link training partner that walks Recovery and Hot Reset on request
`timescale 1ns/1ps
module pbc_ltssm_model (
   input  wire logic sys_clk_i, resetn_i, req_recovery_o, req_hot_reset_o,
   output logic      link_active_i, in_recovery_i, in_hot_reset_i
);
   // One cycle late on every change, so the requester must hold its level
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) {link_active_i, in_recovery_i, in_hot_reset_i} <= 3'b100;
      else {link_active_i, in_recovery_i, in_hot_reset_i} <=
         {!req_recovery_o && !req_hot_reset_o, req_recovery_o, req_hot_reset_o};
   end
endmodule // pbc_ltssm_model

// ---- pbc_bridge_ctrl_bench.sv ----
// Self-checking bench for the bridge control register
`timescale 1ns/1ps
module pbc_bridge_ctrl_bench;
   logic sys_clk_i = 0, resetn_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, io_space_enable_i = 1;
   logic cpu_io_valid_i = 0, cpu_mem_valid_i = 0, master_abort_i = 0, master_abort_is_read_i = 1;
   logic poisoned_cpl_rx_i = 0, parity_flag_clear_i = 0, rd_d = 0, route_graphics_o, route_legacy_o;
   logic ma_complete_o, system_error_o, master_data_parity_error_o, link_active_i, in_recovery_i;
   logic in_hot_reset_i, req_recovery_o, req_hot_reset_o;
   logic [1:0] cfg_be_i = 2'h3;
   logic [2:0] root_err_enable_i = 3'h5, err_msg_rx_i = 3'h0;
   logic [3:0] io_window_base_i = 4'h0, io_window_limit_i = 4'h0;
   logic [7:0] cfg_addr_i = 8'h3e;
   logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o, a, exp_q[$];
   logic [31:0] cpu_addr_i = 32'h0, ma_read_data_o;
   int n_errors = 0, checked = 0, cyc = 0;
   pbc_bridge_ctrl pbc_bridge_ctrl_i (.*);
   pbc_ltssm_model pbc_ltssm_model_i (.*);
   initial forever #10 sys_clk_i = ~sys_clk_i;
   task chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      $display("errors %0d comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A read notes its expected data; the monitor below pairs it with the answer
   task acc(input logic wr, input logic [7:0] ad, input logic [15:0] d);
      if (!wr) exp_q.push_back(d);
      @(posedge sys_clk_i); cfg_wr_i <= wr; cfg_rd_i <= !wr; cfg_addr_i <= ad; cfg_wdata_i <= d;
      @(posedge sys_clk_i); cfg_wr_i <= 0; cfg_rd_i <= 0;
   endtask
   task io(input logic [31:0] ad, input logic mem, g, l);
      @(posedge sys_clk_i); cpu_addr_i <= ad; cpu_io_valid_i <= !mem; cpu_mem_valid_i <= mem;
      @(negedge sys_clk_i); chk("graphics", route_graphics_o, g); chk("legacy", route_legacy_o, l);
   endtask
   task ev(input logic [2:0] e, input logic p, m, s, f);
      @(posedge sys_clk_i); err_msg_rx_i <= e; poisoned_cpl_rx_i <= p; master_abort_i <= m;
      @(negedge sys_clk_i); chk("serr", system_error_o, s);
      if (m) chk("abort data", ma_read_data_o, 32'hffffffff);
      @(posedge sys_clk_i); err_msg_rx_i <= 0; poisoned_cpl_rx_i <= 0; master_abort_i <= 0;
      @(negedge sys_clk_i); chk("parity", master_data_parity_error_o, f);
   endtask
   always @(posedge sys_clk_i) begin
      rd_d <= cfg_rd_i;
      cyc <= cyc + 1;
      if (cyc == 3000) begin n_errors++; end_sim; end
   end
   always @(negedge sys_clk_i) if (rd_d) chk("rdata", cfg_rdata_o, exp_q.pop_front());
   initial begin
      void'($urandom(76997));
      repeat (4) @(posedge sys_clk_i);
      resetn_i <= 1;
      acc(0, 8'h3e, 16'h0000);
      acc(1, 8'h3e, 16'hffff); acc(0, 8'h3e, 16'h005f);
      acc(1, 8'h40, 16'hffff); acc(0, 8'h40, 16'h0000);
      for (int i = 0; i < 20 && !req_hot_reset_o; i++) @(negedge sys_clk_i);
      chk("hot reset", req_hot_reset_o, 1);
      chk("recovery", req_recovery_o, 0);
      io(32'h13c0, 0, 0, 1); io(32'h000a0000, 1, 1, 0);
      ev(3'h4, 1, 1, 1, 1); ev(3'h2, 0, 0, 0, 1);
      @(posedge sys_clk_i); parity_flag_clear_i <= 1;
      @(posedge sys_clk_i); parity_flag_clear_i <= 0;
      @(negedge sys_clk_i); chk("parity clear", master_data_parity_error_o, 0);
      acc(1, 8'h3e, 16'h0008); io(32'h13c0, 0, 1, 0);
      chk("hot reset off", req_hot_reset_o, 0);
      acc(1, 8'h3e, 16'h0010); io(32'h13c0, 0, 0, 1);
      io(32'h000a0000, 1, 0, 1);
      @(posedge sys_clk_i); io_window_limit_i <= 4'hf;
      for (int k = 0; k < 2; k++) begin
         acc(1, 8'h3e, k ? 16'h0004 : 16'h0000);
         repeat (8) begin
            a = 16'($urandom) & 16'hfdff;
            io({16'h0, a}, 0, !(k && a[8]), k && a[8]);
         end
      end
      @(posedge sys_clk_i); io_window_limit_i <= 4'h0;
      io(32'h1100, 0, 0, 1);
      @(posedge sys_clk_i); io_space_enable_i <= 0; root_err_enable_i <= 3'h7;
      io(32'h0, 0, 0, 1);
      ev(3'h7, 1, 0, 0, 0);
      end_sim;
   end
endmodule // pbc_bridge_ctrl_bench
